/* rtl/imp_edge_flag.sv */
`timescale 1ns/1ps
module imp_edge_flag (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic req_in,
	input wire logic clear,
	output logic flag
);
	logic req_prev;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			req_prev <= 1'b0;
		end else begin
			req_prev <= req_in;
		end
	end

	// a new edge in the clearing cycle keeps the flag set
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			flag <= 1'b0;
		end else if (req_in && !req_prev) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule // imp_edge_flag

/* rtl/imp_irq_device.sv */
`timescale 1ns/1ps
module imp_irq_device (
	input wire logic sys_clk,
	input wire logic nrst,
	imp_link_if.dev link,
	input wire logic [15:0] level_req,
	input wire logic [7:0] edge_req
);
	logic [7:0] level_mask_low;
	logic [7:0] level_mask_high;
	logic [7:0] edge_mask;
	logic [7:0] global_irq_control;
	logic [7:0] priority_byte_zero;
	logic [7:0] priority_byte_one;
	logic [7:0] priority_byte_two;
	logic [15:0] level_flag;
	logic [7:0] edge_flag;
	logic [7:0] edge_clear;
	logic [7:0] edge_in;
	logic [23:0] flag_word;
	logic [23:0] mask_word;
	logic [23:0] prio_word;
	logic [23:0] pending;
	logic [23:0] pending_high;
	logic wr_hit;
	logic next_irq_req;
	logic next_irq_high;
	logic [4:0] next_irq_src;
	logic [4:0] low_src;
	logic [4:0] high_src;
	logic [7:0] next_rdata;

	// the host pulses reg_sel once per access, so a write lands exactly once
	assign wr_hit = link.reg_sel && link.reg_wr;

	// software writes: masks, mode and priority; reserved bits never stored
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_mask_low <= imp_pkg::BYTE_RESET;
			level_mask_high <= imp_pkg::BYTE_RESET;
			edge_mask <= imp_pkg::BYTE_RESET;
			global_irq_control <= imp_pkg::BYTE_RESET;
			priority_byte_zero <= imp_pkg::BYTE_RESET;
			priority_byte_one <= imp_pkg::BYTE_RESET;
			priority_byte_two <= imp_pkg::BYTE_RESET;
		end else if (wr_hit) begin
			// flag bytes fall through here: level flags belong to their source modules
			if (link.reg_addr == imp_pkg::LEVEL_MASK_LOW) begin
				level_mask_low <= link.reg_wdata & imp_pkg::LEVEL_LOW_IMPL;
			end else if (link.reg_addr == imp_pkg::LEVEL_MASK_HIGH) begin
				level_mask_high <= link.reg_wdata & imp_pkg::LEVEL_HIGH_IMPL;
			end else if (link.reg_addr == imp_pkg::EDGE_MASK) begin
				edge_mask <= link.reg_wdata & imp_pkg::EDGE_IMPL;
			end else if (link.reg_addr == imp_pkg::GLOBAL_IRQ_CONTROL) begin
				global_irq_control <= link.reg_wdata & imp_pkg::MODE_IMPL;
			end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_ZERO) begin
				priority_byte_zero <= link.reg_wdata & imp_pkg::LEVEL_LOW_IMPL;
			end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_ONE) begin
				priority_byte_one <= link.reg_wdata & imp_pkg::LEVEL_HIGH_IMPL;
			end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_TWO) begin
				priority_byte_two <= link.reg_wdata & imp_pkg::EDGE_IMPL;
			end
		end
	end

	// level flags mirror the source; only the source module can drop them
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_flag <= {imp_pkg::BYTE_RESET, imp_pkg::BYTE_RESET};
		end else begin
			level_flag <= level_req & {imp_pkg::LEVEL_HIGH_IMPL, imp_pkg::LEVEL_LOW_IMPL};
		end
	end

	// write-one-to-clear on the edge byte; other bytes of the flag word ignore writes
	always_comb begin
		edge_clear = imp_pkg::BYTE_RESET;
		if (wr_hit && link.reg_addr == imp_pkg::PENDING_FLAGS_TWO) begin
			edge_clear = link.reg_wdata;
		end
	end

	// reserved edge inputs are tied off so they can never raise a stray flag
	assign edge_in = edge_req & imp_pkg::EDGE_IMPL;

	// one detector per edge lane; reserved lanes are built but only ever see zero
	genvar gi;
	generate
		for (gi = 0; gi < imp_pkg::EDGE_N; gi++) begin : g_edge
			imp_edge_flag u_flag (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.req_in(edge_in[gi]),
				.clear(edge_clear[gi]),
				.flag(edge_flag[gi])
			);
		end
	endgenerate

	// word order: byte zero at bits 7..0, edge byte at bits 23..16
	assign flag_word = {edge_flag, level_flag};
	assign mask_word = {edge_mask, level_mask_high, level_mask_low};
	assign prio_word = {priority_byte_two, priority_byte_one, priority_byte_zero};
	// flags are set whatever the mask; the mask only gates the request
	assign pending = flag_word & mask_word;
	assign pending_high = pending & prio_word;

	// lowest-numbered source wins inside a priority class
	always_comb begin
		low_src = '0;
		high_src = '0;
		for (int i = imp_pkg::SRC_N - 1; i >= 0; i--) begin
			if (pending[i]) begin
				low_src = i[4:0];
			end
			if (pending_high[i]) begin
				high_src = i[4:0];
			end
		end
	end

	// a high-priority source overrides any low-priority one, whatever its index
	always_comb begin
		next_irq_high = |pending_high;
		next_irq_req = global_irq_control[imp_pkg::GLOBAL_EN_BIT] && (|pending);
		if (next_irq_high) begin
			next_irq_src = high_src;
		end else begin
			next_irq_src = low_src;
		end
	end

	// irq_src reads zero with no request, so the host never sees a stale index
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link.irq_req <= 1'b0;
			link.irq_high <= 1'b0;
			link.irq_src <= '0;
		end else begin
			link.irq_req <= next_irq_req;
			link.irq_high <= next_irq_req && next_irq_high;
			link.irq_src <= next_irq_req ? next_irq_src : '0;
		end
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		next_rdata = imp_pkg::BYTE_RESET;
		if (link.reg_addr == imp_pkg::LEVEL_MASK_LOW) begin
			next_rdata = level_mask_low;
		end else if (link.reg_addr == imp_pkg::LEVEL_MASK_HIGH) begin
			next_rdata = level_mask_high;
		end else if (link.reg_addr == imp_pkg::EDGE_MASK) begin
			next_rdata = edge_mask;
		end else if (link.reg_addr == imp_pkg::GLOBAL_IRQ_CONTROL) begin
			next_rdata = global_irq_control;
		end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_ZERO) begin
			next_rdata = priority_byte_zero;
		end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_ONE) begin
			next_rdata = priority_byte_one;
		end else if (link.reg_addr == imp_pkg::PRIORITY_BYTE_TWO) begin
			next_rdata = priority_byte_two;
		// flag bytes are read as they stand, so a dropped level source reads zero one cycle later, once level_flag has registered it
		end else if (link.reg_addr == imp_pkg::PENDING_FLAGS_ZERO) begin
			next_rdata = flag_word[7:0];
		end else if (link.reg_addr == imp_pkg::PENDING_FLAGS_ONE) begin
			next_rdata = flag_word[15:8];
		end else if (link.reg_addr == imp_pkg::PENDING_FLAGS_TWO) begin
			next_rdata = flag_word[23:16];
		end
	end

	// every access is answered exactly one cycle after its select
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link.reg_ack <= 1'b0;
		end else begin
			link.reg_ack <= link.reg_sel;
		end
	end

	// read data is latched at the select edge and held, so the host may take it late
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link.reg_rdata <= imp_pkg::BYTE_RESET;
		end else if (link.reg_sel && !link.reg_wr) begin
			link.reg_rdata <= next_rdata;
		end
	end
endmodule // imp_irq_device

/* rtl/imp_irq_host.sv */
`timescale 1ns/1ps
module imp_irq_host (
	input wire logic sys_clk,
	input wire logic nrst,
	imp_link_if.cpu link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	imp_pkg::imp_host_state_t state;
	logic [11:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic cmd_write;
	logic [7:0] last_rdata;
	logic apb_take;
	logic go;
	logic mapped;
	logic [31:0] next_prdata;

	// one wait state: pready rises in the second access cycle
	assign apb_take = psel && penable && !pready;
	assign go = apb_take && pwrite && paddr == imp_pkg::APB_CMD_CTRL && pwdata[imp_pkg::CTRL_GO_BIT];

	always_comb begin
		next_prdata = '0;
		mapped = 1'b1;
		if (paddr == imp_pkg::APB_CMD_ADDR) begin
			next_prdata[11:0] = cmd_addr;
		end else if (paddr == imp_pkg::APB_CMD_WDATA) begin
			next_prdata[7:0] = cmd_wdata;
		end else if (paddr == imp_pkg::APB_CMD_CTRL) begin
			next_prdata[imp_pkg::CTRL_WRITE_BIT] = cmd_write;
		end else if (paddr == imp_pkg::APB_STATUS) begin
			next_prdata[imp_pkg::STAT_BUSY_BIT] = state != imp_pkg::HS_IDLE;
			next_prdata[imp_pkg::STAT_IRQ_BIT] = link.irq_req;
			next_prdata[imp_pkg::STAT_HIGH_BIT] = link.irq_high;
			next_prdata[imp_pkg::STAT_SRC_LSB +: 5] = link.irq_src;
		end else if (paddr == imp_pkg::APB_RDATA) begin
			next_prdata[7:0] = last_rdata;
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_take;
			pslverr <= apb_take && !mapped;
			if (apb_take && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// command words are frozen while a device access is in flight
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_addr <= '0;
			cmd_wdata <= '0;
			cmd_write <= 1'b0;
		end else if (apb_take && pwrite && state == imp_pkg::HS_IDLE) begin
			if (paddr == imp_pkg::APB_CMD_ADDR) begin
				cmd_addr <= pwdata[11:0];
			end else if (paddr == imp_pkg::APB_CMD_WDATA) begin
				cmd_wdata <= pwdata[7:0];
			end else if (paddr == imp_pkg::APB_CMD_CTRL) begin
				cmd_write <= pwdata[imp_pkg::CTRL_WRITE_BIT];
			end
		end
	end

	// relays software accesses; clearing edge flags and priorities stay software's
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= imp_pkg::HS_IDLE;
			link.reg_sel <= 1'b0;
			link.reg_wr <= 1'b0;
			link.reg_addr <= '0;
			link.reg_wdata <= '0;
			last_rdata <= '0;
		end else begin
			case (state)
				imp_pkg::HS_IDLE: begin
					if (go) begin
						state <= imp_pkg::HS_ISSUE;
					end
				end
				imp_pkg::HS_ISSUE: begin
					link.reg_sel <= 1'b1;
					link.reg_wr <= cmd_write;
					link.reg_addr <= cmd_addr;
					link.reg_wdata <= cmd_wdata;
					state <= imp_pkg::HS_WAIT;
				end
				imp_pkg::HS_WAIT: begin
					link.reg_sel <= 1'b0;
					if (link.reg_ack) begin
						if (!link.reg_wr) begin
							last_rdata <= link.reg_rdata;
						end
						state <= imp_pkg::HS_IDLE;
					end
				end
				default: begin
					state <= imp_pkg::HS_IDLE;
				end
			endcase
		end
	end
endmodule // imp_irq_host

/* rtl/imp_link_if.sv */
`timescale 1ns/1ps
interface imp_link_if;
	logic reg_sel;
	logic reg_wr;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_ack;
	logic irq_req;
	logic irq_high;
	logic [4:0] irq_src;
	modport dev (input reg_sel, reg_wr, reg_addr, reg_wdata,
		output reg_rdata, reg_ack, irq_req, irq_high, irq_src);
	modport cpu (output reg_sel, reg_wr, reg_addr, reg_wdata,
		input reg_rdata, reg_ack, irq_req, irq_high, irq_src);
endinterface

/* rtl/imp_pkg.sv */
package imp_pkg;
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int LEVEL_N = 16;
	localparam int EDGE_N = 8;
	localparam int SRC_N = 24;
	localparam int SRC_ID_W = 5;
	// device register map, one byte per address
	localparam logic [11:0] LEVEL_MASK_LOW = 12'h640;
	localparam logic [11:0] LEVEL_MASK_HIGH = 12'h641;
	localparam logic [11:0] EDGE_MASK = 12'h642;
	localparam logic [11:0] GLOBAL_IRQ_CONTROL = 12'h643;
	localparam logic [11:0] PRIORITY_BYTE_ZERO = 12'h644;
	localparam logic [11:0] PRIORITY_BYTE_ONE = 12'h645;
	localparam logic [11:0] PRIORITY_BYTE_TWO = 12'h646;
	localparam logic [11:0] PENDING_FLAGS_ZERO = 12'h648;
	localparam logic [11:0] PENDING_FLAGS_ONE = 12'h649;
	localparam logic [11:0] PENDING_FLAGS_TWO = 12'h64a;
	// implemented source bits; reserved positions read zero
	localparam logic [7:0] LEVEL_LOW_IMPL = 8'hf7;
	localparam logic [7:0] LEVEL_HIGH_IMPL = 8'he0;
	localparam logic [7:0] EDGE_IMPL = 8'h7c;
	localparam logic [7:0] MODE_IMPL = 8'h01;
	localparam int GLOBAL_EN_BIT = 0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// source positions in the 24-bit flag word
	localparam int SRC_TIMER_ZERO = 0;
	localparam int SRC_TIMER_ONE = 1;
	localparam int SRC_TIMER_TWO = 2;
	localparam int SRC_DMA = 4;
	localparam int SRC_DATA_FIFO = 5;
	localparam int SRC_SERIAL = 6;
	localparam int SRC_HOST_CMD = 7;
	localparam int SRC_BASEBAND = 13;
	localparam int SRC_PWM = 14;
	localparam int SRC_PUBKEY = 15;
	localparam int SRC_PIN_EVENT = 18;
	localparam int SRC_SLOW_TIMER_WAKEUP = 19;
	localparam int SRC_SYSTEM_TIMER = 20;
	localparam int SRC_ROUTED_PIN_LO = 21;
	localparam int SRC_ROUTED_PIN_HI = 22;
	// controller-side apb registers
	localparam logic [7:0] APB_CMD_ADDR = 8'h00;
	localparam logic [7:0] APB_CMD_WDATA = 8'h04;
	localparam logic [7:0] APB_CMD_CTRL = 8'h08;
	localparam logic [7:0] APB_STATUS = 8'h0c;
	localparam logic [7:0] APB_RDATA = 8'h10;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IRQ_BIT = 1;
	localparam int STAT_HIGH_BIT = 2;
	localparam int STAT_SRC_LSB = 8;
	typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} imp_host_state_t;
endpackage

/* verification/imp_link_monitor.sv */
`timescale 1ns/1ps
module imp_link_monitor (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic irq_req,
	input wire logic irq_high,
	input wire logic [4:0] irq_src
);
	// bit n set where flag position n has a real source
	localparam logic [31:0] SRC_IMPL = 32'h007ce0f7;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	ack_timing_a: assert property (reg_sel |=> reg_ack)
		else $error("no ack one cycle after select");
	rsvd_mask0_a: assert property (reg_sel && !reg_wr && reg_addr == 12'h640 |=> !reg_rdata[3])
		else $error("reserved mask bit reads one");
	rsvd_mask1_a: assert property (reg_sel && !reg_wr && reg_addr == 12'h641 |=> reg_rdata[4:0] == 5'h00)
		else $error("reserved mask bits read one");
	rsvd_mask2_a: assert property (reg_sel && !reg_wr && reg_addr == 12'h642 |=> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0)
		else $error("reserved edge mask bits read one");
	mode_rsvd_a: assert property (reg_sel && !reg_wr && reg_addr == 12'h643 |=> reg_rdata[7:1] == 7'h00)
		else $error("reserved mode bits read one");
	global_off_a: assert property (reg_sel && reg_wr && reg_addr == 12'h643 && !reg_wdata[0] |=> ##1 !irq_req)
		else $error("request with global enable off");
	src_valid_a: assert property (irq_req |-> SRC_IMPL[irq_src])
		else $error("request names a reserved source");
	idle_src_a: assert property (!irq_req |-> irq_src == 5'h00 && !irq_high)
		else $error("source shown without request");
	high_req_a: assert property (irq_high |-> irq_req)
		else $error("high priority without request");
	reset_quiet_a: assert property ($rose(nrst) |-> !irq_req && !reg_ack && reg_rdata == 8'h00)
		else $error("outputs not clear after reset");
endmodule // imp_link_monitor

/* verification/soc_irq_mask_priority_flags_tb_top.sv */
`timescale 1ns/1ps
module soc_irq_mask_priority_flags_tb_top;
	typedef struct packed {logic [11:0] addr; logic [7:0] wdata; logic [7:0] back;} imp_row_t;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slverr_q;
	logic [15:0] level_req = 16'h0000;
	logic [7:0] edge_req = 8'h00;
	logic [31:0] r;
	logic [7:0] b;
	int err_total = 0;
	int tests_run = 0;
	imp_row_t rows [11] = '{'{12'h640, 8'hff, 8'hf7}, '{12'h641, 8'hff, 8'he0}, '{12'h642, 8'hff, 8'h7c},
		'{12'h643, 8'hff, 8'h01}, '{12'h644, 8'hff, 8'hf7}, '{12'h645, 8'hff, 8'he0}, '{12'h646, 8'hff, 8'h7c},
		'{12'h648, 8'hff, 8'h00}, '{12'h649, 8'hff, 8'h00}, '{12'h64a, 8'hff, 8'h00}, '{12'h647, 8'hff, 8'h00}};
	imp_link_if link();
	imp_irq_device i_imp_irq_device (.sys_clk(sys_clk), .nrst(nrst), .link(link.dev), .level_req(level_req),
		.edge_req(edge_req));
	imp_irq_host i_imp_irq_host (.sys_clk(sys_clk), .nrst(nrst), .link(link.cpu), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	imp_link_monitor i_imp_link_monitor (.sys_clk(sys_clk), .nrst(nrst), .reg_sel(link.reg_sel), .reg_wr(link.reg_wr),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
		.irq_req(link.irq_req), .irq_high(link.irq_high), .irq_src(link.irq_src));
	always #20 sys_clk = ~sys_clk;
	task wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
			err_total++;
		end
	endtask
	// entered just after a rising edge; pready is looked at as sampled by that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		slverr_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40) begin
			err_total++;
			wrap_up();
		end
		@(posedge sys_clk);
	endtask
	task dev(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		apb(1'b1, imp_pkg::APB_CMD_ADDR, {20'h0, a}, r);
		apb(1'b1, imp_pkg::APB_CMD_WDATA, {24'h0, d}, r);
		apb(1'b1, imp_pkg::APB_CMD_CTRL, (32'(w) << imp_pkg::CTRL_WRITE_BIT) | (32'h1 << imp_pkg::CTRL_GO_BIT), r);
		for (n = 0; n < 20; n++) begin
			apb(1'b0, imp_pkg::APB_STATUS, 32'h0, r);
			if (r[imp_pkg::STAT_BUSY_BIT] === 1'b0)
				break;
		end
		if (n == 20) begin
			err_total++;
			wrap_up();
		end
		apb(1'b0, imp_pkg::APB_RDATA, 32'h0, r);
		q = r[7:0];
	endtask
	task st(input logic irq, input logic high, input logic [4:0] src);
		apb(1'b0, imp_pkg::APB_STATUS, 32'h0, r);
		check(r, (32'(src) << imp_pkg::STAT_SRC_LSB) | (32'(high) << imp_pkg::STAT_HIGH_BIT)
			| (32'(irq) << imp_pkg::STAT_IRQ_BIT), "status");
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		st(1'b0, 1'b0, 5'd0);
		foreach (rows[i]) begin
			dev(1'b0, rows[i].addr, 8'h00, b);
			check(b, 0, "reset value");
			dev(1'b1, rows[i].addr, rows[i].wdata, b);
			dev(1'b0, rows[i].addr, 8'h00, b);
			check(b, rows[i].back, "readback");
		end
		dev(1'b1, 12'h644, 8'h00, b);
		dev(1'b1, 12'h646, 8'h00, b);
		dev(1'b1, 12'h645, 8'h40, b);
		level_req <= 16'h4001;
		dev(1'b0, 12'h648, 8'h00, b);
		check(b, 8'h01, "flag byte zero");
		dev(1'b0, 12'h649, 8'h00, b);
		check(b, 8'h40, "flag byte one");
		st(1'b1, 1'b1, 5'd14);
		dev(1'b1, 12'h645, 8'h00, b);
		st(1'b1, 1'b0, 5'd0);
		// level flags are owned by the source module, a write here must not clear them
		dev(1'b1, 12'h648, 8'hff, b);
		dev(1'b0, 12'h648, 8'h00, b);
		check(b, 8'h01, "level flag kept");
		level_req <= 16'h0001;
		dev(1'b1, 12'h643, 8'h00, b);
		st(1'b0, 1'b0, 5'd0);
		dev(1'b1, 12'h643, 8'h01, b);
		st(1'b1, 1'b0, 5'd0);
		level_req <= 16'h0000;
		dev(1'b0, 12'h648, 8'h00, b);
		check(b, 8'h00, "level flag follows");
		edge_req <= 8'h05;
		@(posedge sys_clk);
		edge_req <= 8'h00;
		dev(1'b0, 12'h64a, 8'h00, b);
		check(b, 8'h04, "edge flag");
		st(1'b1, 1'b0, 5'd18);
		dev(1'b1, 12'h64a, 8'h04, b);
		dev(1'b0, 12'h64a, 8'h00, b);
		check(b, 8'h00, "edge clear");
		st(1'b0, 1'b0, 5'd0);
		dev(1'b1, 12'h642, 8'h6c, b);
		edge_req <= 8'h10;
		@(posedge sys_clk);
		edge_req <= 8'h00;
		dev(1'b0, 12'h64a, 8'h00, b);
		check(b, 8'h10, "masked edge flag");
		st(1'b0, 1'b0, 5'd0);
		apb(1'b0, 8'h14, 32'h0, r);
		check(32'(slverr_q), 32'h1, "unmapped apb");
		// second reset in mid-run, with masks, mode and an edge flag still set
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		dev(1'b0, 12'h642, 8'h00, b);
		check(b, 8'h00, "mask after reset");
		dev(1'b0, 12'h643, 8'h00, b);
		check(b, 8'h00, "mode after reset");
		dev(1'b0, 12'h64a, 8'h00, b);
		check(b, 8'h00, "flag after reset");
		st(1'b0, 1'b0, 5'd0);
		wrap_up();
	end
endmodule // soc_irq_mask_priority_flags_tb_top
